// file: rtl/at_cycle_pkg.sv
// Purpose: shared constants and carriers for the expansion bus cycle controller
// Assumes: 20 MHz core clock, bus clock derived by divider
// Notes: default timing only; address timing knobs come in as plain inputs
package at_cycle_pkg;
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned BUS_CLK_HZ = 10000000;
    localparam int unsigned BUS_DIV = CLK_HZ / BUS_CLK_HZ;
    localparam logic [3:0] WAIT_DEFAULT = 4'h1;
    localparam logic [3:0] WAIT_IO_DEFAULT = 4'h1;

    typedef struct packed {
        logic        is_io;
        logic        is_write;
        logic        word;
        logic [23:0] addr;
        logic [15:0] wdata;
    } cyc_req_s;

    typedef struct packed {
        logic bale;
        logic memr_n;
        logic memw_n;
        logic ior_n;
        logic iow_n;
    } strobes_s;

    typedef struct packed {
        logic system_side_direction;
        logic cpu_side_direction;
        logic low_byte_buffer_enable_n;
        logic high_byte_buffer_enable_n;
        logic system_buffer_enable_n;
    } buf_ctl_s;

    typedef enum logic [5:0] {
        ST_IDLE  = 6'b000001,
        ST_ADDR  = 6'b000010,
        ST_CMD   = 6'b000100,
        ST_WAIT  = 6'b001000,
        ST_END   = 6'b010000,
        ST_DONE  = 6'b100000
    } cyc_state_e;
endpackage

// file: rtl/at_bus_divider.sv
// Purpose: one-cycle enable pulse at the bus clock rate
// Assumes: DIV of at least 1
// Notes: also gives a bus clock level for pins
`timescale 1ns/1ns
module at_bus_divider
    import at_cycle_pkg::*;
#(
    parameter int unsigned DIV = BUS_DIV
)
(
    input wire logic core_clk,
    input wire logic arst_n,
    output logic tick,
    output logic bus_clk_lvl
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic tick_q;
    logic tick_d;
    logic lvl_q;
    logic lvl_d;

    always_comb
    begin
        tick_d = 1'b0;
        lvl_d = lvl_q;
        if (cnt_q == 8'(DIV - 1))
        begin
            cnt_d = 8'h00;
            tick_d = 1'b1;
            lvl_d = ~lvl_q;
        end
        else
        begin
            cnt_d = cnt_q + 8'h01;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_q <= 8'h00;
            tick_q <= 1'b0;
            lvl_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
            lvl_q <= lvl_d;
        end
    end

    assign tick = tick_q;
    assign bus_clk_lvl = lvl_q;
endmodule // at_bus_divider

// file: rtl/at_bus_cycle_control.sv
// Purpose: expansion bus master cycle sequencer
// Assumes: request held stable until done; memcs16_n, iocs16_n, iochrdy and zerows_n are synchronised here, sd_in is not
// Notes: one byte phase per half of a split word write
// Functional notes
// - memory 16-bit response is looked at only in memory cycles
// - i/o 16-bit response is looked at only in i/o cycles
// - memory read and i/o read strobes never active together
// - zero-wait request shortens memory cycles only, never i/o
// - split byte write: system direction low, cpu direction high throughout
// - word write to 8-bit target goes out as two byte cycles
// - address outputs timed by settings, may move off bus clock
// - low byte data may be briefly undefined after its enable
`timescale 1ns/1ns
module at_bus_cycle_control
    import at_cycle_pkg::*;
#(
    parameter logic [3:0] WAITS = WAIT_DEFAULT,
    parameter logic [3:0] WAITS_IO = WAIT_IO_DEFAULT
)
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic req_valid,
    input wire cyc_req_s req,
    input wire logic addr_early,
    input wire logic memcs16_n,
    input wire logic iocs16_n,
    input wire logic iochrdy,
    input wire logic zerows_n,
    input wire logic [15:0] sd_in,
    output logic busy,
    output logic done,
    output logic [15:0] rdata,
    output strobes_s strobes,
    output buf_ctl_s buf_ctl,
    output logic [23:0] addr_out,
    output logic [15:0] sd_out,
    output logic sd_oe,
    output logic bus_clk
);
    logic tick;
    logic bus_clk_lvl;
    logic [1:0] m16_s;
    logic [1:0] i16_s;
    logic [1:0] rdy_s;
    logic [1:0] zws_s;

    cyc_state_e st_q, st_d;
    cyc_req_s r_q, r_d;
    logic hi_q, hi_d;
    logic narrow_q, narrow_d;
    logic [3:0] wcnt_q, wcnt_d;
    logic [15:0] rdata_q, rdata_d;
    strobes_s str_q, str_d;
    buf_ctl_s buf_q, buf_d;
    logic [23:0] addr_q, addr_d;
    logic [15:0] sdo_q, sdo_d;
    logic oe_q, oe_d;
    logic done_q, done_d;
    logic busy_q, busy_d;
    logic clk_q;

    at_bus_divider #(.DIV(BUS_DIV)) u_div (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .tick(tick),
        .bus_clk_lvl(bus_clk_lvl)
    );

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            m16_s <= 2'h3;
            i16_s <= 2'h3;
            rdy_s <= 2'h3;
            zws_s <= 2'h3;
        end
        else
        begin
            m16_s <= {m16_s[0], memcs16_n};
            i16_s <= {i16_s[0], iocs16_n};
            rdy_s <= {rdy_s[0], iochrdy};
            zws_s <= {zws_s[0], zerows_n};
        end
    end

    // a 16-bit answer only counts for the matching cycle type
    function automatic logic wide_ok(input logic is_io, input logic m_n, input logic i_n);
        wide_ok = is_io ? ~i_n : ~m_n;
    endfunction

    function automatic strobes_s cmd(input cyc_req_s r, input logic on);
        cmd = '{bale: 1'b0, memr_n: 1'b1, memw_n: 1'b1, ior_n: 1'b1, iow_n: 1'b1};
        if (on)
        begin
            // exactly one strobe, so both reads can never overlap
            unique case ({r.is_io, r.is_write})
                2'b00: cmd.memr_n = 1'b0;
                2'b01: cmd.memw_n = 1'b0;
                2'b10: cmd.ior_n = 1'b0;
                2'b11: cmd.iow_n = 1'b0;
            endcase
        end
    endfunction

    always_comb
    begin
        st_d = st_q;
        r_d = r_q;
        hi_d = hi_q;
        narrow_d = narrow_q;
        wcnt_d = wcnt_q;
        rdata_d = rdata_q;
        str_d = str_q;
        buf_d = buf_q;
        addr_d = addr_q;
        sdo_d = sdo_q;
        oe_d = oe_q;
        done_d = 1'b0;
        busy_d = busy_q;
        // address may move on the core clock, not only bus ticks
        if (addr_early && st_q != ST_IDLE)
        begin
            addr_d = {r_q.addr[23:1], r_q.addr[0] | hi_q};
        end
        unique case (st_q)
            ST_IDLE:
            begin
                if (req_valid)
                begin
                    r_d = req;
                    hi_d = 1'b0;
                    busy_d = 1'b1;
                    st_d = ST_ADDR;
                end
            end
            ST_ADDR:
            begin
                if (tick)
                begin
                    str_d = cmd(r_q, 1'b0);
                    str_d.bale = 1'b1;
                    addr_d = {r_q.addr[23:1], r_q.addr[0] | hi_q};
                    st_d = ST_CMD;
                end
            end
            ST_CMD:
            begin
                if (tick)
                begin
                    str_d = cmd(r_q, 1'b1);
                    narrow_d = ~wide_ok(r_q.is_io, m16_s[1], i16_s[1]);
                    wcnt_d = r_q.is_io ? WAITS_IO : WAITS;
                    buf_d.system_buffer_enable_n = 1'b0;
                    buf_d.system_side_direction = ~r_q.is_write;
                    buf_d.cpu_side_direction = r_q.is_write;
                    // low and high enables open in the same cycle (high stays shut in the second half); a brief undefined low byte may show
                    buf_d.low_byte_buffer_enable_n = 1'b0;
                    buf_d.high_byte_buffer_enable_n = hi_q;
                    if (r_q.is_write && hi_q)
                    begin
                        buf_d.system_side_direction = 1'b0;
                        buf_d.cpu_side_direction = 1'b1;
                    end
                    sdo_d = hi_q ? {8'h00, r_q.wdata[15:8]} : r_q.wdata;
                    oe_d = r_q.is_write;
                    st_d = ST_WAIT;
                end
            end
            ST_WAIT:
            begin
                if (tick)
                begin
                    if (!r_q.is_io && !zws_s[1])
                    begin
                        wcnt_d = 4'h0;
                    end
                    else if (wcnt_q != 4'h0)
                    begin
                        wcnt_d = wcnt_q - 4'h1;
                    end
                    if (rdy_s[1] && (wcnt_q == 4'h0 || (!r_q.is_io && !zws_s[1])))
                    begin
                        st_d = ST_END;
                    end
                end
            end
            ST_END:
            begin
                if (tick)
                begin
                    str_d = cmd(r_q, 1'b0);
                    if (!r_q.is_write)
                    begin
                        if (hi_q)
                            rdata_d[15:8] = sd_in[7:0];
                        else
                            rdata_d = sd_in;
                    end
                    buf_d.low_byte_buffer_enable_n = 1'b1;
                    buf_d.high_byte_buffer_enable_n = 1'b1;
                    buf_d.system_buffer_enable_n = 1'b1;
                    oe_d = 1'b0;
                    if (r_q.word && narrow_q && !hi_q)
                    begin
                        hi_d = 1'b1;
                        st_d = ST_ADDR;
                    end
                    else
                    begin
                        st_d = ST_DONE;
                    end
                end
            end
            ST_DONE:
            begin
                buf_d.system_side_direction = 1'b1;
                buf_d.cpu_side_direction = 1'b0;
                done_d = 1'b1;
                busy_d = 1'b0;
                st_d = ST_IDLE;
            end
            default:
            begin
                st_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_q <= ST_IDLE;
            r_q <= '0;
            hi_q <= 1'b0;
            narrow_q <= 1'b0;
            wcnt_q <= 4'h0;
            rdata_q <= 16'h0000;
            str_q <= '{bale: 1'b0, memr_n: 1'b1, memw_n: 1'b1, ior_n: 1'b1, iow_n: 1'b1};
            buf_q <= '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
            addr_q <= 24'h000000;
            sdo_q <= 16'h0000;
            oe_q <= 1'b0;
            done_q <= 1'b0;
            busy_q <= 1'b0;
            clk_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            r_q <= r_d;
            hi_q <= hi_d;
            narrow_q <= narrow_d;
            wcnt_q <= wcnt_d;
            rdata_q <= rdata_d;
            str_q <= str_d;
            buf_q <= buf_d;
            addr_q <= addr_d;
            sdo_q <= sdo_d;
            oe_q <= oe_d;
            done_q <= done_d;
            busy_q <= busy_d;
            clk_q <= bus_clk_lvl;
        end
    end

    assign busy = busy_q;
    assign done = done_q;
    assign rdata = rdata_q;
    assign strobes = str_q;
    assign buf_ctl = buf_q;
    assign addr_out = addr_q;
    assign sd_out = sdo_q;
    assign sd_oe = oe_q;
    assign bus_clk = clk_q;
endmodule // at_bus_cycle_control

// file: tb/at_cycle_checker.sv
// Purpose: port-level checks of the bus cycle sequencer
// Assumes: default wait counts
// Notes: split detection uses the odd address of the second half
`timescale 1ns/1ns
module at_cycle_checker
    import at_cycle_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic req_valid,
    input wire cyc_req_s req,
    input wire logic busy,
    input wire logic done,
    input wire strobes_s strobes,
    input wire buf_ctl_s buf_ctl,
    input wire logic [23:0] addr_out,
    input wire logic sd_oe
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    logic cmd;
    logic wr;
    assign wr = !strobes.memw_n || !strobes.iow_n;
    assign cmd = wr || !strobes.memr_n || !strobes.ior_n;
    sequence s_latch;
        strobes.bale;
    endsequence
    sequence s_cmd_start;
        $fell(strobes.bale) && cmd;
    endsequence
    a_reads_apart: assert property (!(!strobes.memr_n && !strobes.ior_n))
        else $error("memory and io read strobes low together");
    a_one_strobe: assert property ($onehot0(~{strobes.memr_n, strobes.memw_n,
        strobes.ior_n, strobes.iow_n}))
        else $error("more than one command strobe low");
    a_latch_then_cmd: assert property ($rose(cmd) |-> $past(strobes.bale))
        else $error("strobe without preceding address latch pulse");
    a_cmd_follows: assert property (s_latch ##1 !strobes.bale |-> s_cmd_start)
        else $error("address latch pulse not followed by strobe");
    a_io_full_len: assert property ($fell(strobes.ior_n) || $fell(strobes.iow_n)
        |-> cmd [*6])
        else $error("io strobe shortened");
    a_strobe_ends: assert property ($rose(cmd) |-> ##[1:60] !cmd)
        else $error("strobe never released");
    a_split_dir: assert property (wr && req.word && addr_out[0] != req.addr[0]
        |-> !buf_ctl.system_side_direction && buf_ctl.cpu_side_direction)
        else $error("direction wrong in split write");
    a_idle_quiet: assert property (!busy |-> !cmd && buf_ctl.low_byte_buffer_enable_n
        && buf_ctl.system_buffer_enable_n)
        else $error("bus active while idle");
    a_done_pulse: assert property (done |-> $past(busy) ##1 !done)
        else $error("done not a single pulse of a cycle");
    a_oe_on_write: assert property (cmd |-> sd_oe == wr)
        else $error("data drive not matching write strobe");
    a_low_en_cmd: assert property (cmd |-> !buf_ctl.low_byte_buffer_enable_n)
        else $error("low byte enable closed during strobe");
endmodule // at_cycle_checker

bind at_bus_cycle_control at_cycle_checker i_chk (.core_clk(core_clk), .arst_n(arst_n),
    .req_valid(req_valid), .req(req), .busy(busy), .done(done), .strobes(strobes),
    .buf_ctl(buf_ctl), .addr_out(addr_out), .sd_oe(sd_oe));

// file: tb/at_card_model.sv
// Purpose: behavioural expansion card on the far side
// Assumes: width answer set by the bench, not decoded
// Notes: read data returned byte-swapped at odd addresses
`timescale 1ns/1ns
module at_card_model
    import at_cycle_pkg::*;
(
    input wire logic core_clk,
    input wire strobes_s strobes,
    input wire logic [23:0] addr_out,
    input wire logic cs16_mem,
    input wire logic cs16_io,
    input wire logic zws,
    input wire logic [3:0] slow,
    input wire logic [15:0] rd_val,
    output logic memcs16_n,
    output logic iocs16_n,
    output logic iochrdy,
    output logic zerows_n,
    output logic [15:0] sd_in
);
    logic [3:0] hold_cnt = 4'h0;
    logic [15:0] last = 16'h0000;
    logic rd;
    assign rd = !strobes.memr_n || !strobes.ior_n;
    assign memcs16_n = !cs16_mem;
    assign iocs16_n = !cs16_io;
    assign zerows_n = !zws;
    // not ready for slow cycles after strobe start, then ready
    assign iochrdy = (hold_cnt == 4'h0);
    always @(posedge core_clk)
    begin
        if (strobes.bale)
            hold_cnt <= slow;
        else if (hold_cnt != 4'h0 && !(strobes.memr_n && strobes.memw_n && rd == 1'b0
            && strobes.ior_n && strobes.iow_n))
            hold_cnt <= hold_cnt - 4'h1;
        if (rd)
            last <= sd_in;
    end
    // released bus shows no stale value
    assign sd_in = !rd ? ~last : (addr_out[0] ? {rd_val[7:0], rd_val[15:8]} : rd_val);
endmodule // at_card_model

// file: tb/testbench.sv
// Purpose: directed scenarios for the bus cycle sequencer
// Assumes: default wait counts, card answers set per scenario
// Notes: strobe length measured in core clocks
`timescale 1ns/1ns
module testbench;
    import at_cycle_pkg::*;
    logic core_clk = 0;
    logic arst_n = 0;
    logic req_valid = 0;
    cyc_req_s req = '0;
    logic addr_early = 0;
    logic cs16_mem = 0, cs16_io = 0, zws = 0;
    logic [3:0] slow = 4'h0;
    logic [15:0] rd_val = 16'hA55A;
    logic memcs16_n, iocs16_n, iochrdy, zerows_n, busy, done, sd_oe, bus_clk;
    logic [15:0] sd_in, rdata, sd_out;
    logic [23:0] addr_out;
    strobes_s strobes;
    buf_ctl_s buf_ctl;
    int error_cnt = 0, n_tests = 0, pulses = 0, len = 0, cur = 0;
    logic [7:0] wb[2];
    logic [23:0] wa[2];
    logic cmd;
    assign cmd = !(strobes.memr_n && strobes.memw_n && strobes.ior_n && strobes.iow_n);

    at_bus_cycle_control i_dut (.core_clk(core_clk), .arst_n(arst_n),
        .req_valid(req_valid), .req(req), .addr_early(addr_early), .memcs16_n(memcs16_n),
        .iocs16_n(iocs16_n), .iochrdy(iochrdy), .zerows_n(zerows_n), .sd_in(sd_in),
        .busy(busy), .done(done), .rdata(rdata), .strobes(strobes), .buf_ctl(buf_ctl),
        .addr_out(addr_out), .sd_out(sd_out), .sd_oe(sd_oe), .bus_clk(bus_clk));
    at_card_model i_card (.core_clk(core_clk), .strobes(strobes), .addr_out(addr_out),
        .cs16_mem(cs16_mem), .cs16_io(cs16_io), .zws(zws), .slow(slow), .rd_val(rd_val),
        .memcs16_n(memcs16_n), .iocs16_n(iocs16_n), .iochrdy(iochrdy),
        .zerows_n(zerows_n), .sd_in(sd_in));

    initial
    begin
        forever #25 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        if (!busy)
            pulses <= 0;
        else if (cmd && cur == 0)
        begin
            if (pulses < 2)
            begin
                wb[pulses] <= sd_out[7:0];
                wa[pulses] <= addr_out;
            end
            pulses <= pulses + 1;
        end
        cur <= cmd ? cur + 1 : 0;
        if (!cmd && cur != 0)
            len <= cur;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input logic io, input logic wr, input logic wd, input logic [23:0] a);
        int n;
        @(negedge core_clk);
        req = '{is_io: io, is_write: wr, word: wd, addr: a, wdata: 16'h3CC3};
        req_valid = 1;
        n = 0;
        // done looked at on the falling edge; request dropped before idle sees it again
        while (done !== 1'b1 && n < 300)
        begin
            @(negedge core_clk);
            n++;
        end
        chk(16'(n < 300), 16'h0001);
        req_valid = 0;
    endtask
    task automatic s_widths();
        cs16_mem = 1;
        cyc(0, 0, 1, 24'h000100);
        chk(16'(pulses), 16'h0001);
        chk(rdata, rd_val);
        cyc(1, 0, 1, 24'h000200);
        chk(16'(pulses), 16'h0002);
        chk(rdata, rd_val);
        cs16_mem = 0;
        cs16_io = 1;
        cyc(1, 0, 1, 24'h000202);
        chk(16'(pulses), 16'h0001);
        cyc(0, 0, 1, 24'h000104);
        chk(16'(pulses), 16'h0002);
        cs16_io = 0;
    endtask
    task automatic s_split();
        cyc(0, 1, 1, 24'h000300);
        chk(16'(pulses), 16'h0002);
        chk({wb[1], wb[0]}, 16'h3CC3);
        chk(wa[1][15:0], 16'h0301);
        cyc(1, 1, 1, 24'h000310);
        chk({wb[1], wb[0]}, 16'h3CC3);
        chk(wa[1][15:0], 16'h0311);
    endtask
    task automatic s_zero_wait();
        int lm, lz;
        logic b;
        cyc(0, 0, 0, 24'h000400);
        lm = len;
        zws = 1;
        cyc(0, 0, 0, 24'h000400);
        lz = len;
        chk(16'(lz < lm), 16'h0001);
        cyc(1, 0, 0, 24'h000040);
        chk(16'(len), 16'(lm));
        zws = 0;
        slow = 4'h6;
        addr_early = 1;
        cyc(1, 1, 0, 24'h000041);
        chk(16'(len > lm), 16'h0001);
        chk(wa[0][15:0], 16'h0041);
        slow = 4'h0;
        b = bus_clk;
        repeat (2) @(negedge core_clk);
        chk({15'h0000, bus_clk}, {15'h0000, ~b});
    endtask
    task automatic results();
        $display("checks %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        #250000;
        error_cnt++;
        results();
    end
    initial
    begin
        repeat (3) @(negedge core_clk);
        arst_n = 1;
        chk({15'h0000, strobes.memr_n & strobes.ior_n}, 16'h0001);
        s_widths();
        s_split();
        s_zero_wait();
        results();
    end
endmodule // testbench
